// ---- rtc_status_time.sv ----
// rtc status/adjust control and bcd time counters behind a two-wire bus
`timescale 1ns/1ns
`default_nettype none
module rtc_status_time
  import rtc_pkg::*;
#(
  parameter int OSC_STOP_CYCLES  = OSC_STOP_CYC,
  parameter int ADJ_LIMIT_CYCLES = ADJ_LIMIT_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  input  wire logic       xtal_in,
  input  wire logic       crystal_select,
  input  wire logic [2:0] periodic_cycle_sel,
  input  wire logic       alarm_a_enable,
  input  wire logic       alarm_b_enable,
  input  wire logic       alarm_a_match,
  input  wire logic       alarm_b_match,
  output var  logic       irq_out_first_out,
  output var  logic       irq_out_first_oe,
  output var  logic       irq_out_second_out,
  output var  logic       irq_out_second_oe
);
  logic           scl_s;
  logic           sda_s;
  logic           xtal_s;
  logic           xtal_q_r;
  logic           xtal_rise;
  logic [16:0]    stall_r;
  logic           osc_stopped;
  logic [14:0]    pre_r;
  logic [14:0]    pre_last;
  logic           sec_tick;
  logic           halt_r;
  logic           fmt24_r;
  logic           clkout_disable_r;
  logic           per_irq_flag_r;
  logic           alarm_a_flag_r;
  logic           alarm_b_flag_r;
  logic           adj_pend_r;
  logic [7:0]     sec_r;
  logic [7:0]     min_r;
  logic [7:0]     hour_r;
  logic [2:0]     wday_r;
  logic [7:0]     sec_nxt;
  logic [7:0]     min_nxt;
  logic [7:0]     hour_nxt;
  logic [2:0]     wday_nxt;
  logic           min_step;
  logic           hour_step;
  logic           day_step;
  logic           wr_valid;
  reg_wr_t        wr_req;
  logic [3:0]     rd_addr;
  logic [7:0]     rd_data;
  logic           ctrl_wr;
  periodic_mode_t per_mode;
  logic           per_level;
  logic           per_event;
  logic           pulse_low;
  logic           per_irq_flag_rd;
  logic           aen_a;
  logic           aen_b;

  localparam logic PIN_LOW = 1'b0;

  pin_sync #(.WIDTH(3)) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       ({scl_in, sda_in, xtal_in}),
    .q       ({scl_s, sda_s, xtal_s})
  );

  twowire_target u_bus (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .scl_s    (scl_s),
    .sda_s    (sda_s),
    .sda_oe   (sda_oe),
    .wr_valid (wr_valid),
    .wr_req   (wr_req),
    .rd_addr  (rd_addr),
    .rd_data  (rd_data)
  );

  assign sda_out = PIN_LOW;
  assign ctrl_wr = wr_valid && (wr_req.addr == ADDR_CTRL2);

  // oscillator watchdog: no crystal edge for the whole window means stopped
  assign xtal_rise   = xtal_s & ~xtal_q_r;
  assign osc_stopped = (stall_r >= 17'(OSC_STOP_CYCLES - 1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_q_r <= 1'b1; // matches the synchroniser reset level, so no false edge
      stall_r  <= '0;
    end else begin
      xtal_q_r <= xtal_s;
      if (xtal_s != xtal_q_r) stall_r <= '0;
      else if (!osc_stopped) stall_r <= stall_r + 17'd1;
    end
  end

  // prescaler: the halt forces crystal select low, so 32.768 kHz is assumed then
  assign pre_last = (crystal_select && !halt_r) ? PRE_LAST_32000 : PRE_LAST_32768;
  assign sec_tick = xtal_rise && (pre_r == pre_last) && !adj_pend_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= '0;
    end else if (adj_pend_r) begin
      pre_r <= '0;
    end else if (xtal_rise) begin
      pre_r <= (pre_r == pre_last) ? 15'h0000 : pre_r + 15'h0001;
    end
  end

  // halt flag: power-up reset sets it, a stop sets it, set wins over the clearing write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_r <= 1'b1;
    end else if (osc_stopped) begin
      halt_r <= 1'b1;
    end else if (ctrl_wr) begin
      halt_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt24_r          <= 1'b0;
      clkout_disable_r <= 1'b0;
      adj_pend_r       <= 1'b0;
    end else begin
      adj_pend_r <= ctrl_wr && wr_req.data[CTRL_ADJ];
      if (ctrl_wr) fmt24_r <= wr_req.data[CTRL_FMT24];
      if (halt_r) clkout_disable_r <= 1'b0;
      else if (ctrl_wr) clkout_disable_r <= wr_req.data[CTRL_CLKOUT_DIS];
    end
  end

  always_comb begin
    sec_nxt   = sec_r;
    min_nxt   = min_r;
    hour_nxt  = hour_r;
    wday_nxt  = wday_r;
    min_step  = 1'b0;
    hour_step = 1'b0;
    day_step  = 1'b0;
    if (adj_pend_r) begin
      sec_nxt  = BCD_ZERO;
      min_step = (sec_r >= SEC_HALF);
    end else if (sec_tick) begin
      min_step = (sec_r == BCD_LAST59);
      sec_nxt  = min_step ? BCD_ZERO : bcd_inc(sec_r);
    end
    if (min_step) begin
      hour_step = (min_r == BCD_LAST59);
      min_nxt   = hour_step ? BCD_ZERO : bcd_inc(min_r);
    end
    if (hour_step) begin
      hour_nxt = hour_next(hour_r, fmt24_r);
      day_step = fmt24_r ? (hour_r == HOUR24_LAST) : (hour_r == HOUR12_PM11);
    end
    if (day_step) wday_nxt = (wday_r == WDAY_LAST) ? WDAY_FIRST : wday_r + 3'h1;
    // a host write replaces the counted value; only valid values are expected here
    if (wr_valid) begin
      if (wr_req.addr == ADDR_SEC) sec_nxt = wr_req.data & SEC_MASK;
      else if (wr_req.addr == ADDR_MIN) min_nxt = wr_req.data & SEC_MASK;
      else if (wr_req.addr == ADDR_HOUR) hour_nxt = wr_req.data & HOUR_MASK;
      else if (wr_req.addr == ADDR_WDAY) wday_nxt = wr_req.data[2:0];
    end
  end

  // digit fields have no defined reset value; zero is used
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_r  <= BCD_ZERO;
      min_r  <= BCD_ZERO;
      hour_r <= BCD_ZERO;
      wday_r <= WDAY_FIRST;
    end else begin
      sec_r  <= sec_nxt;
      min_r  <= min_nxt;
      hour_r <= hour_nxt;
      wday_r <= wday_nxt;
    end
  end

  // periodic interrupt
  assign per_mode  = halt_r ? PER_OFF : periodic_mode_t'(periodic_cycle_sel);
  assign per_level = per_mode inside {PER_SEC, PER_MIN, PER_HOUR, PER_MONTH};

  always_comb begin
    case (per_mode)
      PER_SEC:   per_event = sec_tick || adj_pend_r;
      PER_MIN:   per_event = hour_step || (min_step && !hour_step);
      PER_HOUR:  per_event = hour_step;
      PER_MONTH: per_event = day_step;
      default:   per_event = 1'b0;
    endcase
    case (per_mode)
      PER_LOW: pulse_low = 1'b1;
      PER_2HZ: pulse_low = ~pre_r[PRE_BIT_2HZ];
      PER_1HZ: pulse_low = ~pre_r[PRE_BIT_1HZ];
      default: pulse_low = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_irq_flag_r <= 1'b0;
    end else if (!per_level) begin
      per_irq_flag_r <= 1'b0;
    end else if (per_event) begin
      per_irq_flag_r <= 1'b1;
    end else if (ctrl_wr && !wr_req.data[CTRL_PER_FLAG]) begin
      per_irq_flag_r <= 1'b0;
    end
  end

  assign per_irq_flag_rd = per_level ? per_irq_flag_r : pulse_low;

  // alarm flags: a disable wins, then a match, then the write of zero
  assign aen_a = alarm_a_enable && !halt_r;
  assign aen_b = alarm_b_enable && !halt_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_a_flag_r <= 1'b0;
      alarm_b_flag_r <= 1'b0;
    end else begin
      if (!aen_a) alarm_a_flag_r <= 1'b0;
      else if (alarm_a_match) alarm_a_flag_r <= 1'b1;
      else if (ctrl_wr && !wr_req.data[CTRL_ALARM_A_FLAG]) alarm_a_flag_r <= 1'b0;
      if (!aen_b) alarm_b_flag_r <= 1'b0;
      else if (alarm_b_match) alarm_b_flag_r <= 1'b1;
      else if (ctrl_wr && !wr_req.data[CTRL_ALARM_B_FLAG]) alarm_b_flag_r <= 1'b0;
    end
  end

  // default routing: alarms and periodic on the first pin, crystal clock on the second
  assign irq_out_first_out  = PIN_LOW;
  assign irq_out_first_oe   = !halt_r && (per_irq_flag_rd || alarm_a_flag_r || alarm_b_flag_r);
  assign irq_out_second_out = PIN_LOW;
  // the halt releases the clock at once, before the forced disable bit has settled
  assign irq_out_second_oe  = (halt_r || !clkout_disable_r) && !xtal_s;

  always_comb begin
    if (rd_addr == ADDR_SEC) rd_data = sec_r & SEC_MASK;
    else if (rd_addr == ADDR_MIN) rd_data = min_r & SEC_MASK;
    else if (rd_addr == ADDR_HOUR) rd_data = hour_r & HOUR_MASK;
    else if (rd_addr == ADDR_WDAY) rd_data = {5'b00000, wday_r};
    else if (rd_addr == ADDR_CTRL2) rd_data = {2'b00, fmt24_r, halt_r, clkout_disable_r,
                                               per_irq_flag_rd, alarm_a_flag_r, alarm_b_flag_r};
    else rd_data = 8'h00;
  end

  // checks
  logic [15:0] adj_wait_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) adj_wait_r <= '0;
    else if (ctrl_wr && wr_req.data[CTRL_ADJ]) adj_wait_r <= 16'h0001;
    else if (adj_wait_r != '0 && sec_r != BCD_ZERO) adj_wait_r <= adj_wait_r + 16'h0001;
    else adj_wait_r <= '0;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_adj_zero;
    adj_pend_r && !wr_valid |=> sec_r == BCD_ZERO && pre_r == '0;
  endproperty
  a_adj_zero: assert property (p_adj_zero) else $error("round adjust did not zero seconds");

  property p_adj_min_hold;
    adj_pend_r && sec_r < SEC_HALF && !wr_valid |=> $stable(min_r);
  endproperty
  a_adj_min_hold: assert property (p_adj_min_hold) else $error("minutes moved on low adjust");

  property p_adj_time;
    adj_wait_r < 16'(ADJ_LIMIT_CYCLES);
  endproperty
  a_adj_time: assert property (p_adj_time) else $error("round adjust too slow");

  property p_halt_read;
    rd_addr == ADDR_CTRL2 |-> rd_data[CTRL_HALT] == halt_r;
  endproperty
  a_halt_read: assert property (p_halt_read) else $error("halt flag not at its read position");

  property p_halt_set;
    osc_stopped |=> halt_r ##1 (halt_r || $past(ctrl_wr));
  endproperty
  a_halt_set: assert property (p_halt_set) else $error("halt flag not held on stop");

  property p_halt_force;
    halt_r |-> per_mode == PER_OFF ##1 (!clkout_disable_r && !alarm_a_flag_r && !alarm_b_flag_r);
  endproperty
  a_halt_force: assert property (p_halt_force) else $error("bits not forced during halt");

  property p_halt_pins;
    halt_r |-> !irq_out_first_oe && (irq_out_second_oe == !xtal_s);
  endproperty
  a_halt_pins: assert property (p_halt_pins) else $error("pins wrong during halt");

  property p_halt_clear;
    ctrl_wr && !osc_stopped |=> !halt_r;
  endproperty
  a_halt_clear: assert property (p_halt_clear) else $error("control write left halt set");

  property p_clkout_off;
    clkout_disable_r && !halt_r |-> !irq_out_second_oe;
  endproperty
  a_clkout_off: assert property (p_clkout_off) else $error("clock out not disabled");

  property p_alarm_off;
    !aen_a |=> !alarm_a_flag_r;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("disabled alarm flag set");

  property p_sec_wrap;
    sec_tick && sec_r == BCD_LAST59 && !wr_valid |=> sec_r == BCD_ZERO && min_r != $past(min_r);
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds wrap did not carry");

  property p_wday_wrap;
    day_step && wday_r == WDAY_LAST && !wr_valid |=> wday_r == WDAY_FIRST;
  endproperty
  a_wday_wrap: assert property (p_wday_wrap) else $error("weekday did not wrap");

  c_adjust: cover property (adj_pend_r && sec_r >= SEC_HALF);
  c_halt_clear: cover property (halt_r ##1 !halt_r);
  c_alarm: cover property (!alarm_a_flag_r ##1 alarm_a_flag_r);
  c_day: cover property (day_step);
endmodule
`default_nettype wire

// ---- rtc_pkg.sv ----
// constants, types and helpers shared by the rtc status and time counter block
// Operation
// - writing round-adjust zeroes prescaler and seconds; seconds 30-59 also step minutes
// - the round adjust completes well inside 122 us after the write
// - round-adjust bit is write only; its read position shows the halt flag
// - halt flag sets when the oscillator stops and stays set after restart
// - while halted, crystal, cycle, alarm enable, route and clock-out bits read zero
// - while halted, first irq pin floats and second pin carries crystal pulses
// - any control write while the oscillator runs clears the halt flag
// - clock-out disable 0 gives crystal pulses on the pin, 1 stops them
// - periodic flag reads 1 exactly while the periodic output pulls low
// - in level mode writing 0 clears the periodic flag, writing 1 does nothing
// - an enabled alarm match sets its flag and pulls the irq pin low
// - writing 0 clears an alarm flag and releases the pin; 1 does nothing
// - a disabled alarm never operates and its flag reads 0
// - seconds and minutes count BCD 00 to 59 and carry on wrap
// - hours carry to the day at 11 pm to 12 am or 23 to 00
// - weekday counts 0 to 6 and wraps to 0
// - unused upper bits of the time registers read zero
// - format bit 1 is 24-hour; 0 is 12-hour with bit 5 marking pm
// - control register two sits at address f with adjust and halt on bit 4
// - alarm match acts only while its enable bit is 1
package rtc_pkg;
  localparam logic [3:0] ADDR_SEC   = 4'h0;
  localparam logic [3:0] ADDR_MIN   = 4'h1;
  localparam logic [3:0] ADDR_HOUR  = 4'h2;
  localparam logic [3:0] ADDR_WDAY  = 4'h3;
  localparam logic [3:0] ADDR_CTRL2 = 4'hf;

  localparam int CTRL_FMT24        = 5;
  localparam int CTRL_ADJ          = 4;
  localparam int CTRL_HALT         = 4;
  localparam int CTRL_CLKOUT_DIS   = 3;
  localparam int CTRL_PER_FLAG     = 2;
  localparam int CTRL_ALARM_A_FLAG = 1;
  localparam int CTRL_ALARM_B_FLAG = 0;

  localparam logic [7:0] SEC_MASK   = 8'h7f;
  localparam logic [7:0] HOUR_MASK  = 8'h3f;
  localparam logic [2:0] WDAY_LAST  = 3'h6;
  localparam logic [2:0] WDAY_FIRST = 3'h0;
  localparam logic [7:0] BCD_ZERO   = 8'h00;
  localparam logic [7:0] BCD_LAST59 = 8'h59;
  localparam logic [7:0] SEC_HALF   = 8'h30;
  localparam logic [7:0] HOUR24_LAST  = 8'h23;
  localparam logic [7:0] HOUR12_PM11  = 8'h31;
  localparam logic [7:0] HOUR12_AM11  = 8'h11;
  localparam logic [7:0] HOUR12_PM12  = 8'h32;
  localparam logic [7:0] HOUR12_AM12  = 8'h12;
  localparam logic [4:0] HOUR12_TWELVE = 5'h12;
  localparam logic [4:0] HOUR12_ONE    = 5'h01;

  localparam logic [14:0] PRE_LAST_32768 = 15'h7fff;
  localparam logic [14:0] PRE_LAST_32000 = 15'h7cff;
  localparam int PRE_BIT_2HZ = 13;
  localparam int PRE_BIT_1HZ = 14;

  localparam int CLK_MHZ       = 100;
  localparam int ADJ_LIMIT_NS  = 122000;
  localparam int ADJ_LIMIT_CYC = ADJ_LIMIT_NS * CLK_MHZ / 1000;
  localparam int OSC_STOP_NS   = 1000000;
  localparam int OSC_STOP_CYC  = OSC_STOP_NS * CLK_MHZ / 1000;

  // two-wire target address; value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5a;

  typedef enum logic [2:0] {
    PER_OFF, PER_LOW, PER_2HZ, PER_1HZ, PER_SEC, PER_MIN, PER_HOUR, PER_MONTH
  } periodic_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction

  function automatic logic [7:0] hour_next(input logic [7:0] h, input logic fmt24);
    logic [7:0] r;
    r = bcd_inc(h);
    if (fmt24) begin
      if (h == HOUR24_LAST) r = BCD_ZERO;
    end else if (h == HOUR12_PM11) begin
      r = HOUR12_AM12;
    end else if (h == HOUR12_AM11) begin
      r = HOUR12_PM12;
    end else if (h[4:0] == HOUR12_TWELVE) begin
      r = {2'b00, h[5], HOUR12_ONE};
    end
    return r;
  endfunction
endpackage

// ---- pin_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // idle-high reset matches open-drain bus lines
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- twowire_target.sv ----
// two-wire bus target: address, register pointer, auto-increment writes and reads
`timescale 1ns/1ns
`default_nettype none
module twowire_target
  import rtc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       scl_s,
  input  wire logic       sda_s,
  output var  logic       sda_oe,
  output var  logic       wr_valid,
  output var  reg_wr_t    wr_req,
  output var  logic [3:0] rd_addr,
  input  wire logic [7:0] rd_data
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DEV_ACK, ST_PTR, ST_PTR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } tw_state_t;

  tw_state_t  state_r;
  logic       scl_q_r;
  logic       sda_q_r;
  logic [7:0] shift_r;
  logic [3:0] cnt_r;
  logic       rw_r;
  logic       nack_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;

  assign scl_rise = scl_s & ~scl_q_r;
  assign scl_fall = ~scl_s & scl_q_r;
  assign start_ev = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_ev  = scl_s & scl_q_r & ~sda_q_r & sda_s;
  assign rd_addr  = wr_req.addr;

  always_comb begin
    case (state_r)
      ST_DEV_ACK, ST_PTR_ACK, ST_WR_ACK: sda_oe = 1'b1;
      ST_RD:                             sda_oe = ~shift_r[7];
      default:                           sda_oe = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  // register writes go out as one-cycle pulses on ref_clk, never on bus edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ST_IDLE;
      shift_r     <= 8'h00;
      cnt_r       <= 4'h0;
      rw_r        <= 1'b0;
      nack_r      <= 1'b0;
      wr_valid    <= 1'b0;
      wr_req      <= '0;
    end else begin
      wr_valid <= 1'b0;
      if (start_ev) begin
        state_r <= ST_DEV;
        cnt_r   <= 4'h0;
      end else if (stop_ev) begin
        state_r <= ST_IDLE;
      end else if (scl_rise) begin
        if (state_r == ST_DEV || state_r == ST_PTR || state_r == ST_WR) begin
          shift_r <= {shift_r[6:0], sda_s};
          cnt_r   <= cnt_r + 4'h1;
        end
        if (state_r == ST_RD_ACK) nack_r <= sda_s;
      end else if (scl_fall) begin
        case (state_r)
          ST_DEV: if (cnt_r == 4'h8) begin
            rw_r    <= shift_r[0];
            state_r <= (shift_r[7:1] == DEV_ADDR) ? ST_DEV_ACK : ST_IDLE;
          end
          ST_DEV_ACK: begin
            cnt_r <= 4'h0;
            if (rw_r) begin
              shift_r <= rd_data;
              state_r <= ST_RD;
            end else begin
              state_r <= ST_PTR;
            end
          end
          ST_PTR: if (cnt_r == 4'h8) begin
            wr_req.addr <= shift_r[7:4];
            state_r     <= ST_PTR_ACK;
          end
          ST_PTR_ACK, ST_WR_ACK: begin
            cnt_r   <= 4'h0;
            state_r <= ST_WR;
          end
          ST_WR: if (cnt_r == 4'h8) begin
            wr_req.data <= shift_r;
            wr_valid    <= 1'b1;
            state_r     <= ST_WR_ACK;
          end
          ST_RD: if (cnt_r == 4'h7) begin
            wr_req.addr <= wr_req.addr + 4'h1;
            state_r     <= ST_RD_ACK;
          end else begin
            shift_r <= {shift_r[6:0], 1'b0};
            cnt_r   <= cnt_r + 4'h1;
          end
          ST_RD_ACK: begin
            cnt_r   <= 4'h0;
            shift_r <= rd_data;
            state_r <= nack_r ? ST_IDLE : ST_RD;
          end
          default: state_r <= ST_IDLE;
        endcase
      end else if (state_r == ST_WR_ACK && wr_valid) begin
        wr_req.addr <= wr_req.addr + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- host_model.sv ----
// two-wire bus host model that reaches the rtc registers by internal address
`timescale 1ns/1ns
`default_nettype none
module host_model
  import rtc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // each hold spans 8 clocks, twice the minimum, so the synchronisers never race; scl high lasts one hold, scl low two
  task automatic hold();
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic start();
    sda_low <= 1'b1;
    hold();
    scl <= 1'b0;
    hold();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    hold();
    scl <= 1'b1;
    hold();
    sda_low <= 1'b0;
    hold();
  endtask
  // nine slots: eight data bits, then the acknowledge slot in bit 0
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= ~d[i];
      hold();
      scl <= 1'b1;
      hold();
      q[i] = sda_line;
      scl <= 1'b0;
      hold();
    end
  endtask
  task automatic point(input logic [3:0] addr, output logic nak);
    logic [8:0] q0;
    logic [8:0] q1;
    start();
    xfer({DEV_ADDR_DEFAULT, 2'b01}, q0);
    xfer({addr, 5'h01}, q1);
    nak = q0[0] | q1[0];
  endtask
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data, output logic nak);
    logic [8:0] q;
    point(addr, nak);
    xfer({data, 1'b1}, q);
    nak = nak | q[0];
    stop();
  endtask
  task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
    logic [8:0] q;
    logic       nak;
    point(addr, nak);
    stop();
    start();
    xfer({DEV_ADDR_DEFAULT, 2'b11}, q);
    xfer(9'h1ff, q);
    data = q[8:1];
    stop();
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the rtc status and time counter block
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import rtc_pkg::*;
;
  logic       ref_clk, rst_n, xtal_in, xtal_run, scl, sda_low, sda_line, sda_out, sda_oe;
  logic       alarm_a_enable, alarm_b_enable, alarm_a_match, alarm_b_match;
  logic       irq1_out, irq1_oe, irq2_out, irq2_oe;
  logic [2:0] periodic_cycle_sel;
  logic [7:0] adj_sec [3] = '{8'h29, 8'h30, 8'h59};
  logic [7:0] adj_min [3] = '{8'h17, 8'h18, 8'h18};
  logic [7:0] raw_wr [4]  = '{8'hd9, 8'hd9, 8'he3, 8'hfe};
  logic [7:0] raw_rd [4]  = '{8'h59, 8'h59, 8'h23, 8'h06};
  int         errors, cmp_count;

  assign sda_line = ~(sda_low | sda_oe);

  host_model host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  rtc_status_time #(.OSC_STOP_CYCLES(64)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .xtal_in(xtal_in), .crystal_select(1'b0), .periodic_cycle_sel(periodic_cycle_sel),
    .alarm_a_enable(alarm_a_enable), .alarm_b_enable(alarm_b_enable), .alarm_a_match(alarm_a_match),
    .alarm_b_match(alarm_b_match), .irq_out_first_out(irq1_out), .irq_out_first_oe(irq1_oe),
    .irq_out_second_out(irq2_out), .irq_out_second_oe(irq2_oe));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // crystal runs far faster than real so the halt detector and clock output show quickly
  initial begin
    xtal_in = 1'b0;
    forever begin
      repeat (3) @(posedge ref_clk);
      if (xtal_run) xtal_in <= ~xtal_in;
    end
  end

  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(a, d);
    check(d, exp);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic nak;
    host.write_reg(a, d, nak);
    check({7'h0, nak}, 8'h00);
  endtask
  // 1 when the second pin toggled within the span, 0 when it held one state throughout
  task automatic clkout_seen(input logic [7:0] exp);
    int hi;
    hi = 0;
    repeat (48) begin
      @(negedge ref_clk);
      hi += int'(irq2_oe === 1'b1);
    end
    check(8'((hi != 0) && (hi != 48)), exp);
  endtask
  task automatic pulse(input logic sel_b);
    alarm_a_match <= !sel_b;
    alarm_b_match <= sel_b;
    @(posedge ref_clk);
    alarm_a_match <= 1'b0;
    alarm_b_match <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  initial begin
    repeat (80000) @(posedge ref_clk);
    errors++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    logic [8:0] q;
    rst_n = 1'b0;
    xtal_run = 1'b1;
    periodic_cycle_sel = 3'h0;
    {alarm_a_enable, alarm_b_enable, alarm_a_match, alarm_b_match} = 4'h0;
    errors = 0;
    cmp_count = 0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd_check(ADDR_CTRL2, 8'h10);
    check({7'h0, irq1_oe}, 8'h00);
    check({5'h0, sda_out, irq1_out, irq2_out}, 8'h00);
    clkout_seen(8'h01);
    wr(ADDR_CTRL2, 8'h20);
    rd_check(ADDR_CTRL2, 8'h20);
    wr(ADDR_CTRL2, 8'h28);
    rd_check(ADDR_CTRL2, 8'h28);
    clkout_seen(8'h00);
    wr(ADDR_CTRL2, 8'h20);
    clkout_seen(8'h01);
    // weekday value keeps its low bits off 7; all values are valid times
    for (int i = 0; i < 4; i++) begin
      wr(4'(i), raw_wr[i]);
      rd_check(4'(i), raw_rd[i]);
    end
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_SEC, adj_sec[i]);
      wr(ADDR_MIN, 8'h17);
      wr(ADDR_CTRL2, 8'h30);
      rd_check(ADDR_SEC, 8'h00);
      rd_check(ADDR_MIN, adj_min[i]);
      rd_check(ADDR_CTRL2, 8'h20);
    end
    alarm_a_enable <= 1'b1;
    pulse(1'b0);
    rd_check(ADDR_CTRL2, 8'h22);
    check({7'h0, irq1_oe}, 8'h01);
    wr(ADDR_CTRL2, 8'h22);
    rd_check(ADDR_CTRL2, 8'h22);
    wr(ADDR_CTRL2, 8'h20);
    rd_check(ADDR_CTRL2, 8'h20);
    check({7'h0, irq1_oe}, 8'h00);
    pulse(1'b1);
    rd_check(ADDR_CTRL2, 8'h20);
    alarm_b_enable <= 1'b1;
    pulse(1'b1);
    rd_check(ADDR_CTRL2, 8'h21);
    alarm_b_enable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd_check(ADDR_CTRL2, 8'h20);
    periodic_cycle_sel <= 3'h1;
    repeat (4) @(posedge ref_clk);
    rd_check(ADDR_CTRL2, 8'h24);
    check({7'h0, irq1_oe}, 8'h01);
    periodic_cycle_sel <= 3'h0;
    repeat (4) @(posedge ref_clk);
    rd_check(ADDR_CTRL2, 8'h20);
    // every-second level mode: the round adjust counts as a seconds step and raises the flag
    periodic_cycle_sel <= 3'h4;
    wr(ADDR_CTRL2, 8'h34);
    rd_check(ADDR_CTRL2, 8'h24);
    check({7'h0, irq1_oe}, 8'h01);
    wr(ADDR_CTRL2, 8'h24);
    rd_check(ADDR_CTRL2, 8'h24);
    wr(ADDR_CTRL2, 8'h20);
    rd_check(ADDR_CTRL2, 8'h20);
    check({7'h0, irq1_oe}, 8'h00);
    periodic_cycle_sel <= 3'h0;
    host.start();
    host.xfer({DEV_ADDR_DEFAULT ^ 7'h01, 2'b01}, q);
    host.stop();
    check({7'h0, q[0]}, 8'h01);
    wr(ADDR_CTRL2, 8'h28);
    xtal_run <= 1'b0;
    repeat (100) @(posedge ref_clk);
    xtal_run <= 1'b1;
    repeat (10) @(posedge ref_clk);
    host.read_reg(ADDR_CTRL2, d);
    check(d & 8'h1f, 8'h10);
    pulse(1'b0);
    host.read_reg(ADDR_CTRL2, d);
    check(d & 8'h1f, 8'h10);
    check({7'h0, irq1_oe}, 8'h00);
    clkout_seen(8'h01);
    print_verdict();
  end
endmodule
`default_nettype wire
